// [hdl/ceb_exec.v]
// Execution unit for interrupt latches, exchanges, block ops, 16-bit math, rotates, call and return
// Function
// - Reset and disable clear both latches; enable sets
// - Special accumulator loads copy shadow latch to P/V
// - Nonmaskable accept clears primary; return restores it
// - Bank swap exchanges three pairs, 4 T
// - EB swaps pointers, 08 swaps accumulator-flag pair
// - Single block copy moves, steps, 16 T
// - Repeating copy: 21 T per pass, 16 last
// - Repeating block P/V zero only at completion
// - Block compare sets N, Z on equality
// - 16-bit add selects operand, 11 T, carry
// - Accumulator rotates, 4 T, carry from shifted bit
// - Call pushes high then low; 10/17 T
// - Return pops low then high; 10 T, conditional 5/11 T
`timescale 1ns/1ps
`include "ceb_map.vh"

module ceb_exec (
	// Clock and reset
	input wire ref_clk,
	input wire resetn,
	// Instruction issue
	input wire instr_valid,
	input wire instr_ed,
	input wire [7:0] instr_op,
	input wire [15:0] instr_imm,
	input wire [15:0] instr_next_pc,
	output wire instr_ready,
	output reg instr_done,
	output reg instr_repeat,
	output reg instr_illegal,
	// Interrupt side
	input wire nmi_req,
	output reg nmi_taken,
	input wire [7:0] int_vector_reg,
	input wire [7:0] refresh_count,
	output reg interrupt_enable_primary,
	output reg interrupt_enable_shadow,
	// Memory
	output reg [15:0] mem_addr,
	output reg [7:0] mem_wdata,
	output reg mem_rd,
	output reg mem_wr,
	input wire [7:0] mem_rdata,
	// Register state
	output reg [7:0] reg_a,
	output reg [7:0] reg_f,
	output reg [15:0] counter_pair,
	output reg [15:0] pointer_pair_second,
	output reg [15:0] pointer_pair_third,
	output reg [15:0] reg_sp,
	output reg [15:0] reg_pc
);

	localparam ST_IDLE = 1'b0;
	localparam ST_EXEC = 1'b1;

	localparam C_ILLEGAL = 4'd0;
	localparam C_DI = 4'd1;
	localparam C_EI = 4'd2;
	localparam C_LDSPEC = 4'd3;
	localparam C_RETURN_FROM_NONMASKABLE = 4'd4;
	localparam C_EXX = 4'd5;
	localparam C_EXDH = 4'd6;
	localparam C_EXAF = 4'd7;
	localparam C_COPY = 4'd8;
	localparam C_CMP = 4'd9;
	localparam C_ADD16 = 4'd10;
	localparam C_ADC16 = 4'd11;
	localparam C_ROT = 4'd12;
	localparam C_CALL = 4'd13;
	localparam C_RET = 4'd14;

	reg state;
	reg [4:0] cnt;
	reg [4:0] step;
	reg cur_ed;
	reg [7:0] cur_op;
	reg [15:0] cur_imm;
	reg [15:0] cur_npc;
	reg cur_take;
	reg [7:0] tmp_lo;
	reg [7:0] tmp_hi;
	reg [7:0] alt_a;
	reg [7:0] alt_f;
	reg [15:0] alt_bc;
	reg [15:0] alt_de;
	reg [15:0] alt_hl;

	// ----------------------------------------------------------------
	// Decode helpers
	// ----------------------------------------------------------------
	function [3:0] op_class;
		input ed;
		input [7:0] op;
		begin
			op_class = C_ILLEGAL;
			if (ed) begin
				if (op == `CEB_ED_LD_A_IV || op == `CEB_ED_LD_A_RF)
					op_class = C_LDSPEC;
				else if (op == `CEB_ED_RETURN_FROM_NONMASKABLE)
					op_class = C_RETURN_FROM_NONMASKABLE;
				else if (op == `CEB_ED_COPY_UP || op == `CEB_ED_COPY_DN || op == `CEB_ED_COPY_RUP
					|| op == `CEB_ED_COPY_RDN)
					op_class = C_COPY;
				else if (op == `CEB_ED_CMP_UP)
					op_class = C_CMP;
				else if (op[7:6] == 2'b01 && op[2:0] == 3'b010)
					op_class = C_ADC16;
			end else begin
				if (op == `CEB_OP_DI)
					op_class = C_DI;
				else if (op == `CEB_OP_EI)
					op_class = C_EI;
				else if (op == `CEB_OP_EXX)
					op_class = C_EXX;
				else if (op == `CEB_OP_EX_DE_HL)
					op_class = C_EXDH;
				else if (op == `CEB_OP_EX_AF)
					op_class = C_EXAF;
				else if (op == `CEB_OP_RLCA || op == `CEB_OP_RLA || op == `CEB_OP_ACC_ROTATE_RIGHT_CIRCULAR || op == `CEB_OP_RRA)
					op_class = C_ROT;
				else if (op[7:6] == 2'b00 && op[3:0] == 4'b1001)
					op_class = C_ADD16;
				else if (op == `CEB_OP_CALL || (op[7:6] == 2'b11 && op[2:0] == 3'b100))
					op_class = C_CALL;
				else if (op == `CEB_OP_RET || (op[7:6] == 2'b11 && op[2:0] == 3'b000))
					op_class = C_RET;
			end
		end
	endfunction

	// Condition codes: NZ, Z, NC, C, PO, PE, P, M
	function cond_true;
		input [2:0] cc;
		input [7:0] f;
		begin
			case (cc[2:1])
				2'b00: cond_true = f[`CEB_F_Z] == cc[0];
				2'b01: cond_true = f[`CEB_F_C] == cc[0];
				2'b10: cond_true = f[`CEB_F_PV] == cc[0];
				default: cond_true = f[`CEB_F_S] == cc[0];
			endcase
		end
	endfunction

	function [15:0] pair_sel;
		input [1:0] ss;
		input [15:0] bc;
		input [15:0] de;
		input [15:0] hl;
		input [15:0] sp;
		begin
			case (ss)
				2'b00: pair_sel = bc;
				2'b01: pair_sel = de;
				2'b10: pair_sel = hl;
				default: pair_sel = sp;
			endcase
		end
	endfunction

	wire [3:0] in_class = op_class(instr_ed, instr_op);
	wire [3:0] cls = op_class(cur_ed, cur_op);
	wire in_take = instr_op == `CEB_OP_CALL || instr_op == `CEB_OP_RET || cond_true(instr_op[5:3], reg_f);
	wire cur_uncond = cur_op == `CEB_OP_CALL || cur_op == `CEB_OP_RET;

	// ----------------------------------------------------------------
	// Cycle count of the incoming instruction
	// ----------------------------------------------------------------
	reg [4:0] in_tstates;
	always @* begin
		case (in_class)
			C_LDSPEC: in_tstates = `CEB_T_LD_A_SPECIAL;
			C_RETURN_FROM_NONMASKABLE: in_tstates = `CEB_T_RETURN_FROM_NONMASKABLE;
			C_COPY: in_tstates = (instr_op[4] && counter_pair != 16'h0001) ? `CEB_T_BLOCK_AGAIN : `CEB_T_BLOCK;
			C_CMP: in_tstates = `CEB_T_BLOCK;
			C_ADD16: in_tstates = `CEB_T_ADD16;
			C_ADC16: in_tstates = `CEB_T_ADC16;
			C_CALL: in_tstates = in_take ? `CEB_T_CALL : `CEB_T_CALL_SKIP;
			C_RET: in_tstates = instr_op == `CEB_OP_RET ? `CEB_T_RET
				: (in_take ? `CEB_T_RET_TAKEN : `CEB_T_RET_SKIP);
			default: in_tstates = `CEB_T_SHORT;
		endcase
	end

	// ----------------------------------------------------------------
	// Arithmetic for the commit cycle
	// ----------------------------------------------------------------
	wire [15:0] add_src = pair_sel(cur_op[5:4], counter_pair, pointer_pair_second, pointer_pair_third, reg_sp);
	wire carry_in = cur_ed & reg_f[`CEB_F_C];
	wire [16:0] sum17 = {1'b0, pointer_pair_third} + {1'b0, add_src} + {16'h0000, carry_in};
	wire [16:0] dif17 = {1'b0, pointer_pair_third} - {1'b0, add_src} - {16'h0000, reg_f[`CEB_F_C]};
	wire [12:0] sum_h = {1'b0, pointer_pair_third[11:0]} + {1'b0, add_src[11:0]} + {12'h000, carry_in};
	wire [12:0] dif_h = {1'b0, pointer_pair_third[11:0]} - {1'b0, add_src[11:0]}
		- {12'h000, reg_f[`CEB_F_C]};
	wire is_sub = ~cur_op[3];
	wire [15:0] res16 = is_sub ? dif17[15:0] : sum17[15:0];
	wire ovf_add = (pointer_pair_third[15] == add_src[15]) && (res16[15] != pointer_pair_third[15]);
	wire ovf_sub = (pointer_pair_third[15] != add_src[15]) && (res16[15] != pointer_pair_third[15]);
	wire [8:0] cmp9 = {1'b0, reg_a} - {1'b0, tmp_lo};
	wire [4:0] cmp_h = {1'b0, reg_a[3:0]} - {1'b0, tmp_lo[3:0]};
	wire [15:0] bc_dec = counter_pair - 16'h0001;
	wire [15:0] sp_dn1 = reg_sp - 16'h0001;
	wire [15:0] sp_dn2 = reg_sp - 16'h0002;
	wire [15:0] sp_up1 = reg_sp + 16'h0001;
	wire [15:0] sp_up2 = reg_sp + 16'h0002;
	wire [15:0] step_ptr = cur_op[3] ? 16'hFFFF : 16'h0001;

	assign instr_ready = state == ST_IDLE;

	// ----------------------------------------------------------------
	// Sequencer, memory steps and commit
	// ----------------------------------------------------------------
	always @(posedge ref_clk) begin
		if (!resetn) begin
			state <= ST_IDLE;
			cnt <= 5'd0;
			step <= 5'd0;
			cur_ed <= 1'b0;
			cur_op <= `CEB_RST_BYTE;
			cur_imm <= `CEB_RST_WORD;
			cur_npc <= `CEB_RST_WORD;
			cur_take <= 1'b0;
			tmp_lo <= `CEB_RST_BYTE;
			tmp_hi <= `CEB_RST_BYTE;
			instr_done <= 1'b0;
			instr_repeat <= 1'b0;
			instr_illegal <= 1'b0;
			nmi_taken <= 1'b0;
			interrupt_enable_primary <= 1'b0;
			interrupt_enable_shadow <= 1'b0;
			mem_addr <= `CEB_RST_WORD;
			mem_wdata <= `CEB_RST_BYTE;
			mem_rd <= 1'b0;
			mem_wr <= 1'b0;
			reg_a <= `CEB_RST_BYTE;
			reg_f <= `CEB_RST_BYTE;
			counter_pair <= `CEB_RST_WORD;
			pointer_pair_second <= `CEB_RST_WORD;
			pointer_pair_third <= `CEB_RST_WORD;
			reg_sp <= `CEB_RST_WORD;
			reg_pc <= `CEB_RST_WORD;
			alt_a <= `CEB_RST_BYTE;
			alt_f <= `CEB_RST_BYTE;
			alt_bc <= `CEB_RST_WORD;
			alt_de <= `CEB_RST_WORD;
			alt_hl <= `CEB_RST_WORD;
		end else begin
			instr_done <= 1'b0;
			instr_repeat <= 1'b0;
			instr_illegal <= 1'b0;
			nmi_taken <= 1'b0;
			mem_rd <= 1'b0;
			mem_wr <= 1'b0;
			case (state)
				ST_IDLE: begin
					if (instr_valid) begin
						cur_ed <= instr_ed;
						cur_op <= instr_op;
						cur_imm <= instr_imm;
						cur_npc <= instr_next_pc;
						cur_take <= in_take;
						// Accept cycle counts as the first T state
						cnt <= in_tstates - 5'd2;
						step <= 5'd0;
						state <= ST_EXEC;
					end
				end
				ST_EXEC: begin
					step <= step + 5'd1;
					cnt <= cnt - 5'd1;
					// Memory reads return combinationally while mem_rd is high
					if ((cls == C_COPY || cls == C_CMP) && step == 5'd0) begin
						mem_addr <= pointer_pair_third;
						mem_rd <= 1'b1;
					end
					if ((cls == C_COPY || cls == C_CMP) && step == 5'd1)
						tmp_lo <= mem_rdata;
					if (cls == C_COPY && step == 5'd1) begin
						mem_addr <= pointer_pair_second;
						mem_wdata <= mem_rdata;
						mem_wr <= 1'b1;
					end
					if (cls == C_CALL && cur_take && step == 5'd0) begin
						mem_addr <= sp_dn1;
						mem_wdata <= cur_npc[15:8];
						mem_wr <= 1'b1;
					end
					if (cls == C_CALL && cur_take && step == 5'd1) begin
						mem_addr <= sp_dn2;
						mem_wdata <= cur_npc[7:0];
						mem_wr <= 1'b1;
					end
					if ((cls == C_RET || cls == C_RETURN_FROM_NONMASKABLE) && (cur_take || cls == C_RETURN_FROM_NONMASKABLE)) begin
						if (step == 5'd0) begin
							mem_addr <= reg_sp;
							mem_rd <= 1'b1;
						end else if (step == 5'd1) begin
							tmp_lo <= mem_rdata;
							mem_addr <= sp_up1;
							mem_rd <= 1'b1;
						end else if (step == 5'd2) begin
							tmp_hi <= mem_rdata;
						end
					end
					if (cnt == 5'd0) begin
						state <= ST_IDLE;
						instr_done <= 1'b1;
						reg_pc <= cur_npc;
						case (cls)
							C_DI: begin
								interrupt_enable_primary <= 1'b0;
								interrupt_enable_shadow <= 1'b0;
							end
							C_EI: begin
								interrupt_enable_primary <= 1'b1;
								interrupt_enable_shadow <= 1'b1;
							end
							C_LDSPEC: begin
								reg_a <= cur_op[3] ? refresh_count : int_vector_reg;
								reg_f[`CEB_F_PV] <= interrupt_enable_shadow;
								reg_f[`CEB_F_S] <= cur_op[3] ? refresh_count[7] : int_vector_reg[7];
								reg_f[`CEB_F_Z] <= (cur_op[3] ? refresh_count : int_vector_reg) == 8'h00;
								reg_f[`CEB_F_H] <= 1'b0;
								reg_f[`CEB_F_N] <= 1'b0;
							end
							C_RETURN_FROM_NONMASKABLE: begin
								interrupt_enable_primary <= interrupt_enable_shadow;
								reg_sp <= sp_up2;
								reg_pc <= {tmp_hi, tmp_lo};
							end
							C_EXX: begin
								counter_pair <= alt_bc;
								alt_bc <= counter_pair;
								pointer_pair_second <= alt_de;
								alt_de <= pointer_pair_second;
								pointer_pair_third <= alt_hl;
								alt_hl <= pointer_pair_third;
							end
							C_EXDH: begin
								pointer_pair_second <= pointer_pair_third;
								pointer_pair_third <= pointer_pair_second;
							end
							C_EXAF: begin
								reg_a <= alt_a;
								reg_f <= alt_f;
								alt_a <= reg_a;
								alt_f <= reg_f;
							end
							C_COPY: begin
								pointer_pair_second <= pointer_pair_second + step_ptr;
								pointer_pair_third <= pointer_pair_third + step_ptr;
								counter_pair <= bc_dec;
								reg_f[`CEB_F_H] <= 1'b0;
								reg_f[`CEB_F_N] <= 1'b0;
								// Only the final repeating pass sees a zero counter
								reg_f[`CEB_F_PV] <= bc_dec != 16'h0000;
								if (cur_op[4] && bc_dec != 16'h0000) begin
									// Pass ends like any instruction so interrupts get in
									instr_repeat <= 1'b1;
									reg_pc <= reg_pc;
								end
							end
							C_CMP: begin
								pointer_pair_third <= pointer_pair_third + 16'h0001;
								counter_pair <= bc_dec;
								reg_f[`CEB_F_S] <= cmp9[7];
								reg_f[`CEB_F_Z] <= cmp9[7:0] == 8'h00;
								reg_f[`CEB_F_H] <= cmp_h[4];
								reg_f[`CEB_F_PV] <= bc_dec != 16'h0000;
								reg_f[`CEB_F_N] <= 1'b1;
							end
							C_ADD16: begin
								pointer_pair_third <= sum17[15:0];
								reg_f[`CEB_F_C] <= sum17[16];
								reg_f[`CEB_F_H] <= sum_h[12];
								reg_f[`CEB_F_N] <= 1'b0;
							end
							C_ADC16: begin
								pointer_pair_third <= res16;
								reg_f[`CEB_F_S] <= res16[15];
								reg_f[`CEB_F_Z] <= res16 == 16'h0000;
								reg_f[`CEB_F_H] <= is_sub ? dif_h[12] : sum_h[12];
								reg_f[`CEB_F_PV] <= is_sub ? ovf_sub : ovf_add;
								reg_f[`CEB_F_N] <= is_sub;
								reg_f[`CEB_F_C] <= is_sub ? dif17[16] : sum17[16];
							end
							C_ROT: begin
								case (cur_op[4:3])
									2'b00: reg_a <= {reg_a[6:0], reg_a[7]};
									2'b10: reg_a <= {reg_a[6:0], reg_f[`CEB_F_C]};
									2'b01: reg_a <= {reg_a[0], reg_a[7:1]};
									default: reg_a <= {reg_f[`CEB_F_C], reg_a[7:1]};
								endcase
								reg_f[`CEB_F_C] <= cur_op[3] ? reg_a[0] : reg_a[7];
								reg_f[`CEB_F_H] <= 1'b0;
								reg_f[`CEB_F_N] <= 1'b0;
							end
							C_CALL: begin
								if (cur_take) begin
									reg_sp <= sp_dn2;
									reg_pc <= cur_imm;
								end
							end
							C_RET: begin
								if (cur_take) begin
									reg_sp <= sp_up2;
									reg_pc <= {tmp_hi, tmp_lo};
								end
							end
							default: instr_illegal <= 1'b1;
						endcase
						// Acceptance follows the instruction's own effect on the latch
						if (nmi_req) begin
							interrupt_enable_primary <= 1'b0;
							nmi_taken <= 1'b1;
						end
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

endmodule // ceb_exec

// [hdl/ceb_map.vh]
// Constants for the exchange, block, arithmetic, rotate and call executor
`ifndef CEB_MAP_VH
`define CEB_MAP_VH

// ----------------------------------------------------------------
// Flag bit positions
// ----------------------------------------------------------------
`define CEB_F_S 7
`define CEB_F_Z 6
`define CEB_F_H 4
`define CEB_F_PV 2
`define CEB_F_N 1
`define CEB_F_C 0

// ----------------------------------------------------------------
// Opcodes (unprefixed, and second byte after the ED prefix)
// ----------------------------------------------------------------
`define CEB_OP_DI 8'hF3
`define CEB_OP_EI 8'hFB
`define CEB_OP_EXX 8'hD9
`define CEB_OP_EX_DE_HL 8'hEB
`define CEB_OP_EX_AF 8'h08
`define CEB_OP_RLCA 8'h07
`define CEB_OP_RLA 8'h17
`define CEB_OP_ACC_ROTATE_RIGHT_CIRCULAR 8'h0F
`define CEB_OP_RRA 8'h1F
`define CEB_OP_CALL 8'hCD
`define CEB_OP_RET 8'hC9
`define CEB_ED_LD_A_IV 8'h57
`define CEB_ED_LD_A_RF 8'h5F
`define CEB_ED_RETURN_FROM_NONMASKABLE 8'h45
`define CEB_ED_COPY_UP 8'hA0
`define CEB_ED_COPY_DN 8'hA8
`define CEB_ED_COPY_RUP 8'hB0
`define CEB_ED_COPY_RDN 8'hB8
`define CEB_ED_CMP_UP 8'hA1

// ----------------------------------------------------------------
// Cycle counts in T states (one T state per ref_clk cycle)
// ----------------------------------------------------------------
`define CEB_T_SHORT 5'd4
`define CEB_T_LD_A_SPECIAL 5'd9
`define CEB_T_BLOCK 5'd16
`define CEB_T_BLOCK_AGAIN 5'd21
`define CEB_T_ADD16 5'd11
`define CEB_T_ADC16 5'd15
`define CEB_T_CALL 5'd17
`define CEB_T_CALL_SKIP 5'd10
`define CEB_T_RET 5'd10
`define CEB_T_RET_TAKEN 5'd11
`define CEB_T_RET_SKIP 5'd5
`define CEB_T_RETURN_FROM_NONMASKABLE 5'd14

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CEB_RST_BYTE 8'h00
`define CEB_RST_WORD 16'h0000

`endif

// [test/ceb_exec_chk.sv]
// Timing and state assertions on the executor ports
`timescale 1ns/1ps

module ceb_exec_chk (
	// Clock and reset
	input wire ref_clk,
	input wire resetn,
	// Issue and status
	input wire instr_valid,
	input wire instr_ed,
	input wire [7:0] instr_op,
	input wire [15:0] instr_imm,
	input wire instr_ready,
	input wire instr_done,
	input wire instr_repeat,
	input wire nmi_taken,
	input wire interrupt_enable_primary,
	input wire interrupt_enable_shadow,
	// State
	input wire [7:0] reg_a,
	input wire [7:0] reg_f,
	input wire [15:0] counter_pair,
	input wire [15:0] pointer_pair_second,
	input wire [15:0] pointer_pair_third,
	input wire [15:0] reg_sp,
	input wire [15:0] reg_pc
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	wire take = instr_valid && instr_ready;
	wire [8:0] code = {instr_ed, instr_op};
	a_reset_latch: assert property (disable iff (1'b0)
		!resetn |=> !interrupt_enable_primary && !interrupt_enable_shadow) else $error("latches not cleared");
	a_enable_sets: assert property (
		take && code == 9'h0FB |-> ##4 nmi_taken || (interrupt_enable_primary && interrupt_enable_shadow))
		else $error("enable did not set latches");
	a_nmi_primary: assert property (
		nmi_taken |-> instr_done && !interrupt_enable_primary) else $error("nmi left primary set");
	a_bank_time: assert property (
		take && code == 9'h0D9 |-> ##1 !instr_done [*3] ##1 instr_done) else $error("bank swap timing");
	a_pointer_swap: assert property (
		take && code == 9'h0EB |-> ##4 pointer_pair_second == $past(pointer_pair_third, 4)
		&& pointer_pair_third == $past(pointer_pair_second, 4) && reg_f == $past(reg_f, 4)) else $error("pointer swap");
	a_copy_count: assert property (
		take && (code == 9'h1A0 || code == 9'h1A8) |-> ##16 instr_done && !reg_f[4] && !reg_f[1]
		&& counter_pair == $past(counter_pair, 16) - 16'h0001) else $error("block copy");
	a_repeat_time: assert property (
		take && code == 9'h1B0 && counter_pair != 16'h0001 |-> ##21 instr_done && instr_repeat)
		else $error("repeat pass timing");
	a_repeat_pv: assert property (
		instr_done && instr_repeat |-> reg_f[2] && counter_pair != 16'h0000) else $error("repeat flag");
	a_rotate_left: assert property (
		take && code == 9'h007 |-> ##4 reg_a == {$past(reg_a[6:0], 4), $past(reg_a[7], 4)}
		&& reg_f[0] == $past(reg_a[7], 4)) else $error("rotate left");
	a_call_jump: assert property (
		take && code == 9'h0CD |-> ##17 instr_done && reg_pc == $past(instr_imm, 17)
		&& reg_sp == $past(reg_sp, 17) - 16'h0002) else $error("call jump");
endmodule // ceb_exec_chk

bind ceb_exec ceb_exec_chk i_ceb_exec_chk (.ref_clk, .resetn, .instr_valid, .instr_ed, .instr_op, .instr_imm,
	.instr_ready, .instr_done, .instr_repeat, .nmi_taken, .interrupt_enable_primary, .interrupt_enable_shadow,
	.reg_a, .reg_f, .counter_pair, .pointer_pair_second, .pointer_pair_third, .reg_sp, .reg_pc);

// [test/ceb_mem.sv]
// Behavioural memory standing on the far side of the executor
`timescale 1ns/1ps

module ceb_mem (
	// Clock
	input wire ref_clk,
	// Memory port
	input wire [15:0] mem_addr,
	input wire [7:0] mem_wdata,
	input wire mem_rd,
	input wire mem_wr,
	output wire [7:0] mem_rdata
);
	// Only the low address byte decodes, so 256 bytes stand for the whole space
	reg [7:0] mem [0:255];
	reg [7:0] last = 8'h00;
	integer k;
	// Unwritten cells hold the vector byte an interrupting peripheral supplies; its bit zero stays clear
	localparam [7:0] VECTOR_LOW = 8'hFE;
	initial begin
		for (k = 0; k < 256; k = k + 1) mem[k] = VECTOR_LOW;
	end
	// Outside a read the bus shows the inverse of the last byte, never a stale copy
	assign mem_rdata = mem_rd ? mem[mem_addr[7:0]] : ~last;
	always @(posedge ref_clk) begin
		if (mem_rd) begin
			last <= mem[mem_addr[7:0]];
		end
		if (mem_wr) begin
			mem[mem_addr[7:0]] <= mem_wdata;
		end
	end
endmodule // ceb_mem

// [test/testbench.sv]
// Self-checking bench for the exchange, block, arithmetic, rotate and call executor
`timescale 1ns/1ps

module testbench;
	reg ref_clk = 0, resetn = 0, instr_valid = 0, instr_ed = 0, nmi_req = 0;
	reg [7:0] instr_op = 8'h00, int_vector_reg = 8'h00, refresh_count = 8'h00;
	reg [15:0] instr_imm = 16'h0000;
	wire instr_ready, instr_done, instr_repeat, instr_illegal, nmi_taken, ie_p, ie_s, mem_rd, mem_wr;
	wire [7:0] mem_wdata, mem_rdata, reg_a, reg_f;
	wire [15:0] mem_addr, counter_pair, pointer_pair_second, pointer_pair_third, reg_sp, reg_pc;
	integer fail_count = 0, checks_done = 0, t, t2, i;
	reg rep, nt, il;
	// Rows: prefix, opcode, T states, expected {primary, shadow}
	reg [18:0] rows [0:19] = '{{1'b0, 8'hF3, 8'h04, 2'b00}, {1'b0, 8'hFB, 8'h04, 2'b11}, {1'b0, 8'hD9, 8'h04, 2'b11},
		{1'b0, 8'hEB, 8'h04, 2'b11}, {1'b0, 8'h08, 8'h04, 2'b11}, {1'b0, 8'h07, 8'h04, 2'b11},
		{1'b0, 8'h17, 8'h04, 2'b11}, {1'b0, 8'h0F, 8'h04, 2'b11}, {1'b0, 8'h1F, 8'h04, 2'b11},
		{1'b1, 8'h57, 8'h09, 2'b11}, {1'b1, 8'h5F, 8'h09, 2'b11}, {1'b1, 8'hA0, 8'h10, 2'b11},
		{1'b1, 8'hA8, 8'h10, 2'b11}, {1'b1, 8'hA1, 8'h10, 2'b11}, {1'b0, 8'h09, 8'h0B, 2'b11},
		{1'b1, 8'h4A, 8'h0F, 2'b11}, {1'b1, 8'h42, 8'h0F, 2'b11}, {1'b1, 8'h45, 8'h0E, 2'b11},
		{1'b0, 8'hCD, 8'h11, 2'b11}, {1'b0, 8'hC9, 8'h0A, 2'b11}};

	always #5 ref_clk = ~ref_clk;

	ceb_exec i_ceb_exec (.ref_clk, .resetn, .instr_valid, .instr_ed, .instr_op, .instr_imm,
		.instr_next_pc(16'h0ABC), .instr_ready, .instr_done, .instr_repeat, .instr_illegal, .nmi_req, .nmi_taken,
		.int_vector_reg, .refresh_count, .interrupt_enable_primary(ie_p), .interrupt_enable_shadow(ie_s),
		.mem_addr, .mem_wdata, .mem_rd, .mem_wr, .mem_rdata, .reg_a, .reg_f, .counter_pair,
		.pointer_pair_second, .pointer_pair_third, .reg_sp, .reg_pc);
	ceb_mem i_ceb_mem (.ref_clk, .mem_addr, .mem_wdata, .mem_rd, .mem_wr, .mem_rdata);

	task chk(input [31:0] seen, input [31:0] exp, input string name);
		checks_done = checks_done + 1;
		if (seen !== exp) begin
			fail_count = fail_count + 1;
			$display("mismatch %0s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Request is held until the accepting edge; t counts T states up to the done pulse
	task run(input e, input [7:0] o, input [15:0] im);
		@(posedge ref_clk);
		#1 {instr_valid, instr_ed, instr_op, instr_imm} = {1'b1, e, o, im};
		@(posedge ref_clk);
		#1 instr_valid = 0;
		t = 1;
		while (instr_done !== 1'b1 && t < 40) begin
			@(posedge ref_clk);
			#1 t = t + 1;
		end
		rep = instr_repeat;
		nt = nmi_taken;
		il = instr_illegal;
		// A request that never completes is a failure of its own
		if (instr_done !== 1'b1) begin
			fail_count = fail_count + 1;
			$display("mismatch instr_done expected 1 seen %b", instr_done);
		end
	endtask

	task print_verdict;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	initial begin
		#100000 fail_count = fail_count + 1;
		print_verdict;
	end

	task do_reset;
		resetn = 0;
		repeat (10) @(posedge ref_clk);
		#1 resetn = 1;
	endtask

	initial begin
		do_reset;
		for (i = 0; i < 20; i = i + 1) begin
			run(rows[i][18], rows[i][17:10], 16'h0000);
			chk(t, rows[i][9:2], "t_states");
			chk({ie_p, ie_s}, rows[i][1:0], "latches");
		end
		$display("test table done");
		// Reset in mid-run must clear what the table left behind
		do_reset;
		chk({ie_p, ie_s}, 2'b00, "reset_latches");
		nmi_req = 1;
		run(0, 8'hFB, 0);
		nmi_req = 0;
		chk({nt, ie_p, ie_s}, 3'b101, "nmi_accept");
		// This return leaves the stack pointer at 0002, where the call tests start
		run(1, 8'h45, 0);
		chk({ie_p, ie_s}, 2'b11, "nmi_return");
		$display("test nmi done");
		int_vector_reg = 8'h81;
		refresh_count = 8'h42;
		run(1, 8'h57, 0);
		chk({reg_a, reg_f[2]}, 9'h103, "load_vector");
		run(0, 8'hF3, 0);
		run(1, 8'h5F, 0);
		chk({reg_a, reg_f[2], ie_p, ie_s}, 11'h210, "load_refresh");
		run(1, 8'h57, 0);
		run(0, 8'h07, 0);
		chk({reg_a, reg_f[4], reg_f[1], reg_f[0]}, 11'h019, "rotate_left");
		run(0, 8'h1F, 0);
		chk({reg_a, reg_f[0]}, 9'h103, "rotate_right");
		$display("test latches and rotates done");
		i_ceb_mem.mem[2] = 8'h5A;
		run(1, 8'hA0, 0);
		run(0, 8'h19, 0);
		chk({pointer_pair_third, reg_f[1]}, 17'h00004, "add_pointer");
		run(1, 8'hA0, 0);
		chk(i_ceb_mem.mem[1], 8'h5A, "copied_byte");
		chk({pointer_pair_second, pointer_pair_third}, 32'h00020003, "copy_ptrs");
		chk({counter_pair, reg_f[4], reg_f[2], reg_f[1]}, 19'h7FFF2, "copy_count");
		run(0, 8'hEB, 0);
		chk({pointer_pair_second, pointer_pair_third}, 32'h00030002, "pointer_swap");
		run(0, 8'hD9, 0);
		chk(counter_pair | pointer_pair_second | pointer_pair_third, 16'h0000, "alt_bank");
		run(0, 8'hD9, 0);
		chk(counter_pair, 16'hFFFE, "main_bank");
		i_ceb_mem.mem[2] = 8'h81;
		run(1, 8'hA1, 0);
		chk({reg_f[6], reg_f[1], pointer_pair_third}, 18'h30003, "compare");
		run(1, 8'hB0, 0);
		chk({t[7:0], rep, reg_f[2], counter_pair}, {8'h15, 1'b1, 1'b1, 16'hFFFC}, "repeat_pass");
		run(1, 8'hB8, 0);
		chk({t[7:0], rep, pointer_pair_third}, {8'h15, 1'b1, 16'h0003}, "repeat_down");
		$display("test block ops done");
		run(0, 8'hCD, 16'h1234);
		chk({i_ceb_mem.mem[1], i_ceb_mem.mem[0]}, 16'h0ABC, "pushed_pc");
		chk({reg_sp, reg_pc}, 32'h00001234, "call_state");
		run(0, 8'hC9, 0);
		chk({reg_sp, reg_pc}, 32'h00020ABC, "ret_state");
		run(0, 8'hC4, 16'h1234);
		t2 = t;
		run(0, 8'hCC, 16'h1234);
		chk(t + t2, 16'd27, "cond_call");
		run(0, 8'hC0, 0);
		t2 = t;
		run(0, 8'hC8, 0);
		chk(t + t2, 16'd16, "cond_ret");
		// An unsupported opcode runs the short count and touches no latch
		run(0, 8'h00, 0);
		chk({il, t[7:0], ie_p, ie_s}, {1'b1, 8'h04, 2'b00}, "illegal_op");
		$display("test call and return done");
		print_verdict;
	end
endmodule // testbench
